// File: src/tx_ctrl_defs.svh
`ifndef TX_CTRL_DEFS_SVH
`define TX_CTRL_DEFS_SVH

// ==========================================================
// Serial word layout
`define WORD_BITS          24
`define ADDR_BITS          4
`define DATA_MSB           23
`define DATA_LSB           4
`define CNT_FULL           5'h18

// ==========================================================
// Register addresses
`define ADDR_OPERATION_CONTROL        4'h4
`define ADDR_CONFIG        4'h5

// ==========================================================
// Power-up values
`define OPERATION_CONTROL_RESET       16'h892F
`define CONFIG_RESET       16'hD03F

// ==========================================================
// Operation control fields
`define OP_LO_PORT_SELECT          15
`define OP_RF_HOLD         14
`define OP_IF_HOLD         13
`define OP_MODE_HI         12
`define OP_MODE_LO         11
`define OP_IF_PAIR         10
`define OP_OSC_BAND        9
`define OP_GAIN_HI         8
`define OP_GAIN_LO         6
`define OP_SIDEBAND        5
`define OP_BUF_EN          4
`define OP_MOD_KIND        3
`define OP_STANDBY_N            2
`define OP_TX_STANDBY_N         1
`define OP_SOFT_HARD_SHUTDOWN_PIN       0

// ==========================================================
// Configuration fields
`define CF_IF_SYNTH        15
`define CF_RF_SYNTH        14
`define CF_RESERVED        13
`define CF_BB_LEVEL        12
`define CF_BUF_DIV         11
`define CF_EXT_OSC         10
`define CF_IF_PUMP_HI      9
`define CF_IF_PUMP_LO      8
`define CF_RF_PUMP_HI      7
`define CF_RF_PUMP_LO      6
`define CF_IF_POL          5
`define CF_RF_POL          4
`define CF_IF_BOOST        3
`define CF_RF_BOOST        2
`define CF_LOCK_HI         1
`define CF_LOCK_LO         0

`endif

// File: src/tx_ctrl_pkg.sv
package tx_ctrl_pkg;

    typedef enum logic [1:0] {
        MODE_FM       = 2'h0,
        MODE_CELL     = 2'h1,
        MODE_PCS_HIGH = 2'h2,
        MODE_PCS_LOW  = 2'h3
    } op_mode_t;

    typedef enum logic [1:0] {
        LOCK_TEST = 2'h0,
        LOCK_IF   = 2'h1,
        LOCK_RF   = 2'h2,
        LOCK_BOTH = 2'h3
    } lock_src_t;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'h1,
        PH_SHIFT = 2'h2
    } phase_t;

    typedef struct packed {
        logic [2:0]  cs_sync;
        logic [2:0]  sclk_sync;
        logic [2:0]  sdi_sync;
        logic [2:0]  gate_sync;
        logic [2:0]  hard_shutdown_pin_sync;
        logic [2:0]  if_lock_sync;
        logic [2:0]  rf_lock_sync;
        logic        cs_level;
        logic        sclk_level;
        logic        gate_level;
        logic        hard_shutdown_pin_level;
        phase_t      phase;
        logic [23:0] shift;
        logic [4:0]  count;
        logic [15:0] op;
        logic [15:0] cfg;
        logic        soft_off;
        logic        rf_hold_eff;
        logic        if_hold_eff;
        logic        rf_low_on;
        logic        rf_out1_on;
        logic        rf_out0_on;
        logic        if_pair_high;
        logic        upconv_on;
        logic        mod_on;
        logic        if_pll_on;
        logic        rf_pll_on;
        logic        if_osc_on;
        logic        if_lo_buf_on;
        logic        lock_pin;
    } ctrl_state_t;

endpackage

// File: src/tx_control_config_registers.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_ctrl_defs.svh"

// Function
// - bit 15 picks low-band LO port, default 1
// - boost hold bits need matching boost enable
// - mode field picks FM, cellular, PCS outputs
// - high IF pair forced low in FM mode
// - bit 9 picks high IF oscillator band
// - three-bit IF gain code, default 100
// - bit 5 selects upper sideband, default 1
// - IF LO buffer enable and divide-by-two
// - bit 3 quadrature, else direct oscillator modulation
// - standby clear powers down all but registers
// - transmit standby off equals gate pin low
// - soft shutdown clears registers, bus stays alive
// - config bits 15,14 power down synthesizers
// - bit 12 selects baseband input level
// - bit 10 bypasses internal IF oscillator
// - IF pump current code, default 00
// - RF pump current code, default 00
// - detector polarity bits, default positive
// - acquisition boost enables for both pumps
// - lock field chooses lock pin source
// - 24-bit word, 20 data then 4 address
// - address 4 operation, 5 configuration, low 16
// - both shutdowns lose registers, standby keeps
module tx_control_config_registers
    import tx_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // Serial pins
    input  wire logic        sclk,
    input  wire logic        sdi,
    input  wire logic        cs_n,
    // Override pins
    input  wire logic        transmit_gate_pin,
    input  wire logic        hard_shutdown_pin,
    // Lock detectors
    input  wire logic        if_lock,
    input  wire logic        rf_lock,
    // Operation control fields
    output logic             lo_port_select,
    output logic             rf_boost_hold,
    output logic             if_boost_hold,
    output logic [1:0]       mode_code,
    output logic             rf_low_out_on,
    output logic             rf_out1_on,
    output logic             rf_out0_on,
    output logic             if_pair_high,
    output logic             if_osc_band_select,
    output logic [2:0]       if_gain_code,
    output logic             upper_sideband,
    output logic             if_lo_buf_on,
    output logic             modulation_kind,
    output logic             standby_n,
    output logic             transmit_standby_n,
    output logic             soft_shutdown_n,
    // Configuration fields
    output logic             if_synth_off_n,
    output logic             rf_synth_off_n,
    output logic             baseband_level_select,
    output logic             if_lo_div2,
    output logic             ext_osc_input_select,
    output logic [1:0]       if_pump_current,
    output logic [1:0]       rf_pump_current,
    output logic             if_detector_polarity,
    output logic             rf_detector_polarity,
    output logic             if_acquire_boost,
    output logic             rf_acquire_boost,
    output logic [1:0]       lock_output_source,
    // Power enables and lock pin
    output logic             upconverter_on,
    output logic             modulator_on,
    output logic             if_pll_on,
    output logic             rf_pll_on,
    output logic             if_osc_on,
    output logic             lock_pin
);

    ctrl_state_t st;
    ctrl_state_t next_st;

    // Per-cycle decode helpers
    logic        sclk_rise;
    logic        cs_fall;
    logic        cs_rise;
    logic [19:0] word_data;
    logic [3:0]  word_addr;
    logic        active;
    logic        tx_path;
    logic        if_lock_agree;
    logic        rf_lock_agree;

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_st = st;

        // Three-stage pin synchronisers; a level counts once stages 2 and 3 agree, except sdi, which is taken from stage 3 directly
        next_st.cs_sync      = {st.cs_sync[1:0], cs_n};
        next_st.sclk_sync    = {st.sclk_sync[1:0], sclk};
        next_st.sdi_sync     = {st.sdi_sync[1:0], sdi};
        next_st.gate_sync    = {st.gate_sync[1:0], transmit_gate_pin};
        next_st.hard_shutdown_pin_sync    = {st.hard_shutdown_pin_sync[1:0], hard_shutdown_pin};
        next_st.if_lock_sync = {st.if_lock_sync[1:0], if_lock};
        next_st.rf_lock_sync = {st.rf_lock_sync[1:0], rf_lock};

        if (st.cs_sync[1] == st.cs_sync[2]) begin
            next_st.cs_level = st.cs_sync[2];
        end
        if (st.sclk_sync[1] == st.sclk_sync[2]) begin
            next_st.sclk_level = st.sclk_sync[2];
        end
        if (st.gate_sync[1] == st.gate_sync[2]) begin
            next_st.gate_level = st.gate_sync[2];
        end
        if (st.hard_shutdown_pin_sync[1] == st.hard_shutdown_pin_sync[2]) begin
            next_st.hard_shutdown_pin_level = st.hard_shutdown_pin_sync[2];
        end

        // Edges of the filtered serial levels
        sclk_rise = next_st.sclk_level & ~st.sclk_level;
        cs_fall   = ~next_st.cs_level & st.cs_level;
        cs_rise   = next_st.cs_level & ~st.cs_level;

        // Address in the low nibble, data above it
        word_data = st.shift[`DATA_MSB:`DATA_LSB];
        word_addr = st.shift[`ADDR_BITS-1:0];

        // Serial receiver
        case (st.phase)
            PH_IDLE: begin
                // A falling chip select opens a frame
                if (cs_fall) begin
                    next_st.phase = PH_SHIFT;
                    next_st.count = 5'h0;
                end
            end
            PH_SHIFT: begin
                if (cs_rise) begin
                    next_st.phase = PH_IDLE;
                    // Only a complete word touches the registers
                    if (st.count >= `CNT_FULL) begin
                        if (word_addr == `ADDR_OPERATION_CONTROL) begin
                            if (!word_data[`OP_SOFT_HARD_SHUTDOWN_PIN]) begin
                                // Both registers return to power-up, bus stays alive
                                next_st.op       = `OPERATION_CONTROL_RESET;
                                next_st.cfg      = `CONFIG_RESET;
                                next_st.soft_off = 1'b1;
                            end else begin
                                next_st.op       = word_data[15:0];
                                next_st.soft_off = 1'b0;
                            end
                        end else if (word_addr == `ADDR_CONFIG) begin
                            next_st.cfg = word_data[15:0];
                        end
                    end
                end else if (sclk_rise) begin
                    next_st.shift = {st.shift[`WORD_BITS-2:0], st.sdi_sync[2]};
                    // Saturate so a long frame still counts as complete
                    if (st.count != 5'h1F) begin
                        next_st.count = st.count + 5'h1;
                    end
                end
            end
            default: begin
                next_st.phase = PH_IDLE;
            end
        endcase

        // Hardware shutdown: registers lost, serial bus held off
        if (!next_st.hard_shutdown_pin_level) begin
            next_st.op       = `OPERATION_CONTROL_RESET;
            next_st.cfg      = `CONFIG_RESET;
            next_st.soft_off = 1'b0;
            next_st.phase    = PH_IDLE;
        end

        // Derived controls, computed from the values being loaded
        active  = next_st.hard_shutdown_pin_level & ~next_st.soft_off
                & next_st.op[`OP_STANDBY_N];
        tx_path = active & next_st.op[`OP_TX_STANDBY_N] & next_st.gate_level;

        next_st.upconv_on    = tx_path;
        next_st.mod_on       = tx_path;
        next_st.if_pll_on    = active & next_st.cfg[`CF_IF_SYNTH];
        next_st.rf_pll_on    = active & next_st.cfg[`CF_RF_SYNTH];
        next_st.if_osc_on    = active & ~next_st.cfg[`CF_EXT_OSC];
        next_st.if_lo_buf_on = active & next_st.op[`OP_BUF_EN];

        // Boost holds only act with acquisition boost on
        next_st.rf_hold_eff = next_st.op[`OP_RF_HOLD] & next_st.cfg[`CF_RF_BOOST];
        next_st.if_hold_eff = next_st.op[`OP_IF_HOLD] & next_st.cfg[`CF_IF_BOOST];

        // FM mode always uses the low IF pair
        next_st.if_pair_high = next_st.op[`OP_IF_PAIR]
                             & (next_st.op[`OP_MODE_HI:`OP_MODE_LO] != MODE_FM);

        // Only the output of the selected mode is driven
        next_st.rf_low_on  = 1'b0;
        next_st.rf_out1_on = 1'b0;
        next_st.rf_out0_on = 1'b0;
        case (op_mode_t'(next_st.op[`OP_MODE_HI:`OP_MODE_LO]))
            MODE_FM: begin
                next_st.rf_low_on = tx_path;
            end
            MODE_CELL: begin
                next_st.rf_low_on = tx_path;
            end
            MODE_PCS_HIGH: begin
                next_st.rf_out1_on = tx_path;
            end
            MODE_PCS_LOW: begin
                next_st.rf_out0_on = tx_path;
            end
            default: begin
                next_st.rf_low_on = 1'b0;
            end
        endcase

        // Lock levels count once sync stages 2 and 3 agree
        if_lock_agree = (st.if_lock_sync[1] == st.if_lock_sync[2]);
        rf_lock_agree = (st.rf_lock_sync[1] == st.rf_lock_sync[2]);

        // Lock pin source; the test code drives the pin low
        case (lock_src_t'(next_st.cfg[`CF_LOCK_HI:`CF_LOCK_LO]))
            LOCK_IF: begin
                if (if_lock_agree) begin
                    next_st.lock_pin = st.if_lock_sync[2];
                end
            end
            LOCK_RF: begin
                if (rf_lock_agree) begin
                    next_st.lock_pin = st.rf_lock_sync[2];
                end
            end
            LOCK_BOTH: begin
                if (if_lock_agree && rf_lock_agree) begin
                    next_st.lock_pin = st.if_lock_sync[2] & st.rf_lock_sync[2];
                end
            end
            default: begin
                next_st.lock_pin = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            // Pins read as idle until the synchronisers fill
            st.cs_sync      <= 3'h7;
            st.sclk_sync    <= 3'h0;
            st.sdi_sync     <= 3'h0;
            st.gate_sync    <= 3'h0;
            st.hard_shutdown_pin_sync    <= 3'h0;
            st.if_lock_sync <= 3'h0;
            st.rf_lock_sync <= 3'h0;
            st.cs_level     <= 1'b1;
            st.sclk_level   <= 1'b0;
            st.gate_level   <= 1'b0;
            st.hard_shutdown_pin_level   <= 1'b0;

            // Receiver idle, registers at power-up values
            st.phase        <= PH_IDLE;
            st.shift        <= 24'h000000;
            st.count        <= 5'h00;
            st.op           <= `OPERATION_CONTROL_RESET;
            st.cfg          <= `CONFIG_RESET;
            st.soft_off     <= 1'b0;

            // Derived enables start off
            st.rf_hold_eff  <= 1'b0;
            st.if_hold_eff  <= 1'b0;
            st.rf_low_on    <= 1'b0;
            st.rf_out1_on   <= 1'b0;
            st.rf_out0_on   <= 1'b0;
            st.if_pair_high <= 1'b0;
            st.upconv_on    <= 1'b0;
            st.mod_on       <= 1'b0;
            st.if_pll_on    <= 1'b0;
            st.rf_pll_on    <= 1'b0;
            st.if_osc_on    <= 1'b0;
            st.if_lo_buf_on <= 1'b0;
            st.lock_pin     <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs straight from the state register
    assign lo_port_select        = st.op[`OP_LO_PORT_SELECT];
    assign rf_boost_hold         = st.rf_hold_eff;
    assign if_boost_hold         = st.if_hold_eff;
    assign mode_code             = st.op[`OP_MODE_HI:`OP_MODE_LO];
    assign rf_low_out_on         = st.rf_low_on;
    assign rf_out1_on            = st.rf_out1_on;
    assign rf_out0_on            = st.rf_out0_on;
    assign if_pair_high          = st.if_pair_high;
    assign if_osc_band_select    = st.op[`OP_OSC_BAND];
    assign if_gain_code          = st.op[`OP_GAIN_HI:`OP_GAIN_LO];
    assign upper_sideband        = st.op[`OP_SIDEBAND];
    assign if_lo_buf_on          = st.if_lo_buf_on;
    assign modulation_kind       = st.op[`OP_MOD_KIND];
    assign standby_n             = st.op[`OP_STANDBY_N];
    assign transmit_standby_n    = st.op[`OP_TX_STANDBY_N];
    assign soft_shutdown_n       = ~st.soft_off;

    // Configuration fields
    assign if_synth_off_n        = st.cfg[`CF_IF_SYNTH];
    assign rf_synth_off_n        = st.cfg[`CF_RF_SYNTH];
    assign baseband_level_select = st.cfg[`CF_BB_LEVEL];
    assign if_lo_div2            = st.cfg[`CF_BUF_DIV];
    assign ext_osc_input_select  = st.cfg[`CF_EXT_OSC];
    assign if_pump_current       = st.cfg[`CF_IF_PUMP_HI:`CF_IF_PUMP_LO];
    assign rf_pump_current       = st.cfg[`CF_RF_PUMP_HI:`CF_RF_PUMP_LO];
    assign if_detector_polarity  = st.cfg[`CF_IF_POL];
    assign rf_detector_polarity  = st.cfg[`CF_RF_POL];
    assign if_acquire_boost      = st.cfg[`CF_IF_BOOST];
    assign rf_acquire_boost      = st.cfg[`CF_RF_BOOST];
    assign lock_output_source    = st.cfg[`CF_LOCK_HI:`CF_LOCK_LO];

    // Power enables and lock pin
    assign upconverter_on        = st.upconv_on;
    assign modulator_on          = st.mod_on;
    assign if_pll_on             = st.if_pll_on;
    assign rf_pll_on             = st.rf_pll_on;
    assign if_osc_on             = st.if_osc_on;
    assign lock_pin              = st.lock_pin;

endmodule

`default_nettype wire

// File: dv/tx_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tx_host_model (
    // Clock
    input  wire logic clk_sys,
    // Serial pins
    output logic      sclk,
    output logic      sdi,
    output logic      cs_n
);
    initial begin
        sclk = 1'b0;
        sdi  = 1'b0;
        cs_n = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Sends the first n bits of w, MSB first; each sclk level holds 4 cycles, each sdi bit 8
    task automatic send(input logic [23:0] w, input int n);
        wait_clk(1);
        cs_n = 1'b0;
        wait_clk(4);
        for (int i = 23; i > 23 - n; i--) begin
            sdi = w[i];
            wait_clk(4);
            sclk = 1'b1;
            wait_clk(4);
            sclk = 1'b0;
        end
        wait_clk(4);
        cs_n = 1'b1;
        sdi  = ~sdi;
        wait_clk(10);
    endtask
endmodule
`default_nettype wire

// File: dv/tx_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tx_ctrl_chk (
    // Clock, reset and pins
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       cs_n,
    input wire logic       transmit_gate_pin,
    input wire logic       hard_shutdown_pin,
    input wire logic       rf_lock,
    // Watched outputs
    input wire logic       rf_boost_hold,
    input wire logic       if_boost_hold,
    input wire logic       rf_acquire_boost,
    input wire logic       if_acquire_boost,
    input wire logic [1:0] mode_code,
    input wire logic [2:0] if_gain_code,
    input wire logic       if_pair_high,
    input wire logic       rf_low_out_on,
    input wire logic       rf_out1_on,
    input wire logic       rf_out0_on,
    input wire logic       upconverter_on,
    input wire logic       modulator_on,
    input wire logic       standby_n,
    input wire logic       transmit_standby_n,
    input wire logic       soft_shutdown_n,
    input wire logic       if_pll_on,
    input wire logic       rf_pll_on,
    input wire logic       if_osc_on,
    input wire logic       if_lo_buf_on,
    input wire logic       if_synth_off_n,
    input wire logic       ext_osc_input_select,
    input wire logic [1:0] lock_output_source,
    input wire logic       lock_pin
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_boost_hold_gated: assert property ((!rf_boost_hold || rf_acquire_boost) && (!if_boost_hold || if_acquire_boost))
        else $error("boost hold without boost enable");
    a_fm_pair_low: assert property (mode_code == 2'h0 |-> !if_pair_high)
        else $error("high IF pair in FM mode");
    a_rf_out_mode: assert property (($onehot({rf_low_out_on, rf_out1_on, rf_out0_on}) == upconverter_on)
        && (!rf_out1_on || mode_code == 2'h2) && (!rf_out0_on || mode_code == 2'h3) && (!rf_low_out_on || !mode_code[1]))
        else $error("RF output does not match mode");
    a_tx_path: assert property ((modulator_on == upconverter_on) && (!upconverter_on || (standby_n && transmit_standby_n)))
        else $error("transmit path on while in standby");
    a_standby_off: assert property (!standby_n |-> !if_pll_on && !rf_pll_on && !if_osc_on && !if_lo_buf_on)
        else $error("block powered during standby");
    a_soft_off: assert property (!soft_shutdown_n |-> !upconverter_on && !if_pll_on && !rf_pll_on && !if_osc_on)
        else $error("block powered during soft shutdown");
    a_synth_osc_off: assert property ((!if_synth_off_n |-> !if_pll_on) and (ext_osc_input_select |-> !if_osc_on))
        else $error("IF synthesizer or oscillator on while off");
    a_gate_pin_off: assert property (!transmit_gate_pin [*6] |-> !upconverter_on)
        else $error("upconverter on with gate pin low");
    a_hard_reset: assert property (!hard_shutdown_pin [*6] |-> if_gain_code == 3'h4 && lock_output_source == 2'h3 && !if_pll_on)
        else $error("hard shutdown did not reset");
    a_apply_on_cs: assert property ($changed({if_gain_code, mode_code, lock_output_source}) |-> cs_n && $past(cs_n, 2))
        else $error("register changed inside a frame");
    a_lock_test_low: assert property (lock_output_source == 2'h0 |-> !lock_pin)
        else $error("lock pin high in test code");
    a_lock_rf_src: assert property ((lock_output_source == 2'h2 && !rf_lock) [*6] |-> !lock_pin)
        else $error("lock pin ignores RF lock");
endmodule

bind tx_control_config_registers tx_ctrl_chk i_tx_ctrl_chk (.*);
`default_nettype wire

// File: dv/tx_control_config_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_ctrl_defs.svh"
module tx_control_config_registers_tb_top;
    // ==========================================================
    // Signals
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        transmit_gate_pin = 1'b1;
    logic        hard_shutdown_pin = 1'b1;
    logic        if_lock = 1'b1;
    logic        rf_lock = 1'b1;
    logic        sclk, sdi, cs_n, lo_port_select, rf_boost_hold, if_boost_hold, rf_low_out_on, rf_out1_on;
    logic        rf_out0_on, if_pair_high, if_osc_band_select, upper_sideband, if_lo_buf_on, modulation_kind;
    logic        standby_n, transmit_standby_n, soft_shutdown_n, if_synth_off_n, rf_synth_off_n, if_lo_div2;
    logic        baseband_level_select, ext_osc_input_select, if_detector_polarity, rf_detector_polarity;
    logic        if_acquire_boost, rf_acquire_boost, upconverter_on, modulator_on, if_pll_on, rf_pll_on;
    logic        if_osc_on, lock_pin;
    logic [1:0]  mode_code, if_pump_current, rf_pump_current, lock_output_source;
    logic [2:0]  if_gain_code;
    logic [15:0] exp_op, exp_cfg;
    int          fails = 0;
    int          total_checks = 0;

    always #4 clk_sys = ~clk_sys;

    tx_control_config_registers i_tx_control_config_registers (.*);
    tx_host_model i_tx_host_model (.*);

    // ==========================================================
    // Shared tasks
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [3:0] addr, input logic [15:0] data);
        i_tx_host_model.send({4'h0, data, addr}, 24);
    endtask

    task automatic chk_regs();
        chk("op_fields", {exp_op[15], exp_op[12:11], exp_op[9:5], exp_op[3:1]}, {lo_port_select, mode_code,
            if_osc_band_select, if_gain_code, upper_sideband, modulation_kind, standby_n, transmit_standby_n});
        chk("cfg_fields", {exp_cfg[15:14], exp_cfg[12:0]}, {if_synth_off_n, rf_synth_off_n, baseband_level_select,
            if_lo_div2, ext_osc_input_select, if_pump_current, rf_pump_current, if_detector_polarity,
            rf_detector_polarity, if_acquire_boost, rf_acquire_boost, lock_output_source});
    endtask

    task automatic chk_pwr(input logic [5:0] exp);
        chk("power", exp, {upconverter_on, modulator_on, if_pll_on, rf_pll_on, if_osc_on, if_lo_buf_on});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        exp_op = `OPERATION_CONTROL_RESET;
        exp_cfg = `CONFIG_RESET;
        chk_regs();
        chk_pwr(6'b111110);
        chk("rf_out", 3'b100, {rf_low_out_on, rf_out1_on, rf_out0_on});
        chk("hold_pair", 3'b000, {rf_boost_hold, if_boost_hold, if_pair_high});
        chk("lock_both", 1'b1, lock_pin);
        rf_lock = 1'b0;
        settle(8);
        chk("lock_and", 1'b0, lock_pin);
        $display("t_reset done");
    endtask

    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            exp_op = {3'b011, m[1:0], 11'b1_1_011_0_1_0_111};
            wr(`ADDR_OPERATION_CONTROL, exp_op);
            chk_regs();
            chk("rf_out", {m < 2, m == 2, m == 3}, {rf_low_out_on, rf_out1_on, rf_out0_on});
            chk("pair_high", m != 0, if_pair_high);
            chk("holds", 2'b11, {rf_boost_hold, if_boost_hold});
            chk_pwr(6'b111111);
        end
        $display("t_modes done");
    endtask

    task automatic t_cfg();
        for (int k = 0; k < 4; k++) begin
            exp_cfg = {k[1:0], 4'b0011, k[1:0], k[1:0], 4'b0000, k[1:0]};
            wr(`ADDR_CONFIG, exp_cfg);
            chk_regs();
            chk("holds", 2'b00, {rf_boost_hold, if_boost_hold});
            chk_pwr({2'b11, k[1:0], 2'b01});
            chk("lock_pin", k == 1, lock_pin);
            if_lock = ~if_lock;
            rf_lock = ~rf_lock;
            settle(8);
            chk("lock_pin_flip", k == 2, lock_pin);
            if_lock = ~if_lock;
            rf_lock = ~rf_lock;
        end
        $display("t_cfg done");
    endtask

    task automatic t_refuse();
        // Last four bits sent spell the operation address, data would shut down
        i_tx_host_model.send({4'h0, 16'h0004, `ADDR_OPERATION_CONTROL}, 20);
        chk_regs();
        wr(4'h6, 16'h0000);
        chk_regs();
        $display("t_refuse done");
    endtask

    task automatic t_power();
        exp_op[2] = 1'b0;
        wr(`ADDR_OPERATION_CONTROL, exp_op);
        chk_regs();
        chk_pwr(6'b000000);
        exp_op[2:1] = 2'b10;
        wr(`ADDR_OPERATION_CONTROL, exp_op);
        chk_pwr(6'b001101);
        exp_op[1] = 1'b1;
        wr(`ADDR_OPERATION_CONTROL, exp_op);
        transmit_gate_pin = 1'b0;
        settle(8);
        chk_pwr(6'b001101);
        transmit_gate_pin = 1'b1;
        settle(8);
        chk_pwr(6'b111101);
        $display("t_power done");
    endtask

    task automatic t_soft();
        exp_op[0] = 1'b0;
        wr(`ADDR_OPERATION_CONTROL, exp_op);
        exp_op = `OPERATION_CONTROL_RESET;
        exp_cfg = `CONFIG_RESET;
        chk_regs();
        chk("soft_n", 1'b0, soft_shutdown_n);
        chk_pwr(6'b000000);
        exp_cfg = 16'hD13F;
        wr(`ADDR_CONFIG, exp_cfg);
        chk_regs();
        wr(`ADDR_OPERATION_CONTROL, exp_op);
        chk("soft_n", 1'b1, soft_shutdown_n);
        chk_pwr(6'b111110);
        $display("t_soft done");
    endtask

    task automatic t_hard();
        exp_op = 16'h7EDF;
        wr(`ADDR_OPERATION_CONTROL, exp_op);
        chk_regs();
        hard_shutdown_pin = 1'b0;
        settle(8);
        chk_pwr(6'b000000);
        wr(`ADDR_OPERATION_CONTROL, 16'h7E9F);
        hard_shutdown_pin = 1'b1;
        settle(8);
        exp_op = `OPERATION_CONTROL_RESET;
        exp_cfg = `CONFIG_RESET;
        chk_regs();
        $display("t_hard done");
    endtask

    // ==========================================================
    // Sequence and watchdog
    initial begin
        repeat (3) @(posedge clk_sys);
        #1 resetn = 1'b1;
        settle(10);
        t_reset();
        t_modes();
        t_cfg();
        t_refuse();
        t_power();
        t_soft();
        t_hard();
        end_of_test();
    end

    initial begin
        #160000;
        fails++;
        $display("MISMATCH watchdog expected done seen timeout");
        end_of_test();
    end
endmodule
`default_nettype wire
